// ---- dv/eib_mst.sv ----
// Behavioural two-wire bus master: drives the bus clock and pulls the data line
`timescale 1ns/1ps
module eib_mst (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  // The clock starts driven high; the data line starts released and rests high through the pull-up
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Data moves only in the low phase and stays put while the clock is high
  task automatic bit_io(input logic b, output logic r);
    #40 pull = ~b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask : bit_io
  // Sends the top n bits; only a whole byte gets the acknowledge clock
  task automatic send(input logic [7:0] d, input int n, output logic ack);
    logic r;
    for (int i = 7; i > 7 - n; i--) bit_io(d[i], r);
    ack = 1'b0;
    if (n == 8) begin
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask : send
  // Long low wait lets a slave release its acknowledge before the clock rises
  task automatic start();
    #40 pull = 1'b0;
    #80 scl = 1'b1;
    #80 pull = 1'b1;
    #80 scl = 1'b0;
  endtask : start
  task automatic stop();
    #40 pull = 1'b1;
    #40 scl = 1'b1;
    #80 pull = 1'b0;
    #80;
  endtask : stop
endmodule : eib_mst

// ---- dv/testbench.sv ----
// Bench: bus master model, both device variants, receive stream scoreboard
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_ready = 1'b0;
  logic hold = 1'b0;
  logic scl, pull, oe0_n, oe7_n, sd0, sd7, stby, busy, regs, rd, st_p, sp_p, rx_valid;
  logic [7:0] rx_data;
  logic [31:0] rnd = 32'hEC34;
  logic [31:0] dr = 32'hEC34;
  logic [7:0] q[$];
  logic [7:0] tbl[9] = '{8'hA0, 8'hB0, 8'hA1, 8'hB1, 8'hAE, 8'hBF, 8'hA2, 8'h90, 8'hB8};
  int fails = 0, cmp_count = 0, n_st = 0, n_sp = 0, e_st = 0, e_sp = 0, cyc = 0, dev = 0;
  // Wired-AND of the master and both slaves
  wire sda = ~pull & (oe0_n | sd0) & (oe7_n | sd7);
  always #10 clk = ~clk;
  eib_mst u_mst (.scl(scl), .pull(pull), .sda(sda));
  eib_slave #(.POSITION(eib_pkg::POS_LOW), .PUD_CYCLES(20)) u_dut (.clk(clk),
    .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sd0), .sda_oe_n(oe0_n),
    .standby(stby), .bus_busy(busy), .sel_regs(regs), .sel_read(rd), .start_seen(st_p),
    .stop_seen(sp_p), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
  eib_slave #(.POSITION(eib_pkg::POS_HIGH), .PUD_CYCLES(20)) u_dut7 (.clk(clk),
    .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sd7), .sda_oe_n(oe7_n),
    .standby(), .bus_busy(), .sel_regs(), .sel_read(), .start_seen(), .stop_seen(),
    .rx_data(), .rx_valid(), .rx_ready(1'b1));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    rx_ready <= ~hold & rnd[3];
    n_st <= n_st + st_p;
    n_sp <= n_sp + sp_p;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
    if (oe0_n === 1'b0) chk("sda_out", sd0, 1'b0);
    if (rx_valid === 1'b1 && rx_ready) begin
      chk("rx_data", rx_data, q.size() ? q.pop_front() : 8'hXX);
    end
  end
  // One transfer: START, control byte, n random data bytes, optional STOP
  task automatic xfer(input logic [7:0] c, input int n, input logic fin);
    logic a;
    logic e;
    u_mst.start();
    e_st++;
    dev = (c[7:5] == 3'h5 && c[3:1] == eib_pkg::POS_LOW) ? 1 :
          (c[7:5] == 3'h5 && c[3:1] == eib_pkg::POS_HIGH) ? 2 : 0;
    u_mst.send(c, 8, a);
    chk("ctrl_ack", a, dev != 0);
    chk("busy", busy, 1'b1);
    if (dev == 1) begin
      chk("sel_regs", regs, c[4]);
      chk("sel_read", rd, c[0]);
    end
    for (int i = 0; i < n; i++) begin
      dr = lfsr(dr);
      e = dev == 2 || (dev == 1 && q.size() < eib_pkg::FIFO_DEPTH);
      if (dev == 1 && e) q.push_back(dr[7:0]);
      u_mst.send(dr[7:0], 8, a);
      chk("data_ack", a, e);
      if (!e) dev = 0;
    end
    if (fin) begin
      u_mst.stop();
      e_sp++;
      chk("idle", busy, 1'b0);
      chk("release", oe0_n, 1'b1);
    end
  endtask : xfer
  initial begin
    logic a;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    #3;
    chk("reset_oe", oe0_n, 1'b1);
    // Bus traffic inside the power-up window must be ignored
    u_mst.start();
    chk("early_busy", busy, 1'b0);
    chk("early_stby", stby, 1'b0);
    repeat (20) @(posedge clk);
    #3;
    chk("standby", stby, 1'b1);
    foreach (tbl[i]) xfer(tbl[i], tbl[i][0] ? 0 : 2, i[0]);
    // START in mid-byte drops the partial byte and expects a control byte
    xfer(8'hA0, 0, 1'b0);
    u_mst.send(8'hC3, 4, a);
    xfer(8'hA0, 1, 1'b1);
    repeat (40) @(posedge clk);
    #3;
    chk("drained", rx_valid, 1'b0);
    hold <= 1'b1;
    @(posedge clk);
    #3;
    // Stalled reader: sixteen bytes fit, the next is refused
    xfer(8'hA0, 18, 1'b1);
    hold <= 1'b0;
    repeat (300) @(posedge clk);
    #3;
    chk("empty", rx_valid, 1'b0);
    chk("left", 8'(q.size()), 8'h00);
    chk("starts", 8'(n_st), 8'(e_st));
    chk("stops", 8'(n_sp), 8'(e_sp));
    end_sim();
  end
endmodule : testbench

// ---- rtl/eib_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module eib_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [WIDTH-1:0] mem [DEPTH];
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem[i] <= '0;
        end else if (do_wr && (wr_ptr[AW-1:0] == AW'(i))) begin
          mem[i] <= in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + (AW+1)'(1);
      if (do_rd) rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end
endmodule : eib_fifo

// ---- rtl/eib_pkg.sv ----
// Constants and types shared by the two-wire slave front end and its receive buffer
package eib_pkg;
  // System clock of the block, in MHz
  localparam int CLK_MHZ = 50;
  // Power-up access delay, printed in microseconds, and its cycle count
  localparam int PUD_US = 250;
  localparam int PUD_CYCLES = PUD_US * CLK_MHZ;
  localparam int PUD_CNT_W = 16;
  localparam logic [15:0] PUD_CNT_RST = 16'h0000;
  // Byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  // Control byte codes and device positions
  localparam logic [3:0] CODE_ARRAY = 4'hA;
  localparam logic [3:0] CODE_REGS = 4'hB;
  localparam logic [2:0] POS_LOW = 3'h0;
  localparam logic [2:0] POS_HIGH = 3'h7;
  // Receive buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    st_idle,
    st_bits,
    st_ack,
    st_skip
  } eib_state_t;
endpackage : eib_pkg

// ---- rtl/eib_slave.sv ----
// Two-wire slave front end: framing, addressing, acknowledge and power-up window
`timescale 1ns/1ps
module eib_slave #(
  parameter logic [2:0] POSITION = eib_pkg::POS_LOW,
  parameter int unsigned PUD_CYCLES = eib_pkg::PUD_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic standby,
  output logic bus_busy,
  output logic sel_regs,
  output logic sel_read,
  output logic start_seen,
  output logic stop_seen,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  localparam logic [15:0] PUD_LAST = 16'(PUD_CYCLES - 1);

  logic scl_m;
  logic scl_s;
  logic scl_q;
  logic sda_m;
  logic sda_s;
  logic sda_q;
  logic [15:0] por_cnt;
  eib_pkg::eib_state_t state;
  eib_pkg::eib_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic first_byte;
  logic next_first_byte;
  logic next_sda_oe_n;
  logic next_bus_busy;
  logic next_sel_regs;
  logic next_sel_read;
  logic fifo_in_ready;

  // Pin synchronisers; the clock line is only ever sampled here
  // Three cycles of latency stay small against a 500 ns half bit at full rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  // Bus event decode, on synchronised samples only
  wire start_det = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det = scl_s && scl_q && !sda_q && sda_s;
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire byte_done = (bit_cnt == eib_pkg::BYTE_BITS);
  wire code_array = (shreg[7:4] == eib_pkg::CODE_ARRAY);
  wire code_regs = (shreg[7:4] == eib_pkg::CODE_REGS);
  wire pos_ok = (shreg[3:1] == POSITION);
  wire addr_match = (code_array || code_regs) && pos_ok;
  wire ack_fall = (state == eib_pkg::st_bits) && byte_done && scl_fall;
  // A full buffer withholds the acknowledge so the master sees back-pressure
  wire give_ack = first_byte ? addr_match : fifo_in_ready;
  wire push = ack_fall && !first_byte && fifo_in_ready && standby;

  // Power-up window: bus ignored until the delay has run out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt <= eib_pkg::PUD_CNT_RST;
      standby <= 1'b0;
    end else if (!standby) begin
      por_cnt <= por_cnt + 16'h0001;
      standby <= (por_cnt == PUD_LAST);
    end
  end

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_first_byte = first_byte;
    next_sda_oe_n = sda_oe_n;
    next_bus_busy = bus_busy;
    next_sel_regs = sel_regs;
    next_sel_read = sel_read;
    if (!standby) begin
      next_state = eib_pkg::st_idle;
      next_sda_oe_n = 1'b1;
      next_bus_busy = 1'b0;
    end else if (start_det) begin
      next_state = eib_pkg::st_bits;
      next_bit_cnt = eib_pkg::BIT_CNT_RST;
      next_first_byte = 1'b1;
      next_sda_oe_n = 1'b1;
      next_bus_busy = 1'b1;
    end else if (stop_det) begin
      next_state = eib_pkg::st_idle;
      next_sda_oe_n = 1'b1;
      next_bus_busy = 1'b0;
    end else begin
      unique case (state)
        eib_pkg::st_idle: begin
          next_sda_oe_n = 1'b1;
        end
        eib_pkg::st_bits: begin
          if (scl_rise && !byte_done) begin
            // Sampled on the rising edge, after the low-phase change settled
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (ack_fall) begin
            next_bit_cnt = eib_pkg::BIT_CNT_RST;
            if (give_ack) begin
              next_state = eib_pkg::st_ack;
              next_sda_oe_n = 1'b0;
              if (first_byte) begin
                next_first_byte = 1'b0;
                next_sel_regs = code_regs;
                next_sel_read = shreg[0];
              end
            end else begin
              next_state = eib_pkg::st_skip;
            end
          end
        end
        eib_pkg::st_ack: begin
          if (scl_fall) begin
            next_sda_oe_n = 1'b1;
            // Read data is outside this block: the line stays released
            next_state = sel_read ? eib_pkg::st_skip : eib_pkg::st_bits;
          end
        end
        eib_pkg::st_skip: begin
          next_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= eib_pkg::st_idle;
      bit_cnt <= eib_pkg::BIT_CNT_RST;
      shreg <= eib_pkg::SHIFT_RST;
      first_byte <= 1'b0;
      sda_oe_n <= 1'b1;
      bus_busy <= 1'b0;
      sel_regs <= 1'b0;
      sel_read <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      first_byte <= next_first_byte;
      sda_oe_n <= next_sda_oe_n;
      bus_busy <= next_bus_busy;
      sel_regs <= next_sel_regs;
      sel_read <= next_sel_read;
    end
  end

  // Pulses for the user side; the output value itself is only ever low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      start_seen <= standby && start_det;
      stop_seen <= standby && stop_det;
    end
  end

  eib_fifo #(
    .WIDTH(eib_pkg::FIFO_WIDTH),
    .DEPTH(eib_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(shreg),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  start_busy_a:
    assert property (standby && start_det |=> bus_busy && state == eib_pkg::st_bits)
    else $error("START not taken as bus busy");

  stop_idle_a:
    assert property (standby && stop_det |=> !bus_busy && state == eib_pkg::st_idle && sda_oe_n)
    else $error("STOP did not return to idle");

  por_quiet_a:
    assert property (!standby |-> sda_oe_n && !bus_busy && !start_seen)
    else $error("Activity during power-up window");

  por_delay_a:
    assert property ($rose(standby) |-> $past(por_cnt) == PUD_LAST)
    else $error("Standby reached at wrong count");

  drive_low_scl_a:
    assert property ($changed(sda_oe_n) && !$past(start_det) && !$past(stop_det)
                     |-> !$past(scl_s))
    else $error("Data drive changed while clock high");

  bit_range_a:
    assert property (bit_cnt <= eib_pkg::BYTE_BITS)
    else $error("Bit counter beyond one byte");

  ack_match_a:
    assert property (standby && !start_det && !stop_det && ack_fall && first_byte && addr_match
                     |=> !sda_oe_n && state == eib_pkg::st_ack)
    else $error("Matching control byte not acknowledged");

  nack_skip_a:
    assert property (standby && !start_det && !stop_det && ack_fall && first_byte && !addr_match
                     |=> sda_oe_n && state == eib_pkg::st_skip)
    else $error("Mismatched control byte acknowledged");

  frame_restart_a:
    assert property (standby && start_det |=> bit_cnt == eib_pkg::BIT_CNT_RST && first_byte)
    else $error("START did not restart framing");

  idle_release_a:
    assert property (state == eib_pkg::st_idle || state == eib_pkg::st_skip |-> ##1 sda_oe_n
                     || $past(start_det) || $past(ack_fall))
    else $error("Data line held outside a transfer");

  ack_release_a:
    assert property (state == eib_pkg::st_ack && scl_fall && standby && !start_det && !stop_det
                     |=> sda_oe_n && state != eib_pkg::st_ack)
    else $error("Acknowledge not released after ninth clock");

  push_ack_a:
    assert property (standby && !start_det && !stop_det && ack_fall && !first_byte
                     && fifo_in_ready |=> !sda_oe_n && state == eib_pkg::st_ack && rx_valid)
    else $error("Data byte with room not acknowledged");

  full_nack_a:
    assert property (standby && !start_det && !stop_det && ack_fall && !first_byte
                     && !fifo_in_ready |=> sda_oe_n && state == eib_pkg::st_skip)
    else $error("Data byte acknowledged while buffer full");

  shift_msb_a:
    assert property (standby && !start_det && !stop_det && state == eib_pkg::st_bits && scl_rise
                     && !byte_done |=> shreg == {$past(shreg[6:0]), $past(sda_s)})
    else $error("Bit not shifted in most significant first");

  start_pulse_a:
    assert property (standby && start_det |=> start_seen)
    else $error("START not reported");

  stop_pulse_a:
    assert property (standby && stop_det |=> stop_seen)
    else $error("STOP not reported");

  ctrl_latch_a:
    assert property (standby && !start_det && !stop_det && ack_fall && first_byte && addr_match
                     |=> sel_read == $past(shreg[0]) && sel_regs == $past(code_regs))
    else $error("Control byte direction or target not latched");

  ack_only_a:
    assert property (!sda_oe_n |-> state == eib_pkg::st_ack && standby)
    else $error("Data line pulled outside the acknowledge slot");
endmodule : eib_slave
